//--- src/dps_pkg.sv
/*
 * Shared constants, types and field layout for the dual pot serial block.
 * Assumes a single 10 MHz system clock; all pins come from outside it.
 */
package dps_pkg;

  // System clock rate and derived nonvolatile write time
  localparam int CLK_MHZ = 10;
  localparam int NV_WRITE_TIME_US = 10000;
  // Longest time, so the count never falls short
  localparam int NV_WRITE_CYCLES = NV_WRITE_TIME_US * CLK_MHZ;
  localparam int NV_CNT_W = 17;

  // Array geometry
  localparam int POTS = 2;
  localparam int PRESETS = 4;
  localparam int WIPER_W = 6;
  localparam int TAPS = 64;
  localparam logic [5:0] WIPER_MAX = 6'h3F;
  localparam logic [5:0] WIPER_MIN = 6'h00;
  localparam logic [5:0] PRESET_RESET = 6'h00;

  // Identification byte fields
  localparam int ID_TYPE_HI = 7;
  localparam int ID_TYPE_LO = 4;
  localparam int ID_ZERO_HI = 3;
  localparam int ID_ZERO_LO = 2;
  localparam int ID_ADDR_HI = 1;
  localparam int ID_ADDR_LO = 0;
  // Arbitrary device type code, not tied to any real part
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'hA;

  // Instruction byte fields
  localparam int OP_HI = 7;
  localparam int OP_LO = 4;
  localparam int REG_HI = 3;
  localparam int REG_LO = 2;
  localparam int POT_BIT = 0;

  // Bit counter end value
  localparam logic [2:0] BIT_LAST = 3'h7;

  typedef enum logic [3:0] {
    OP_GLOBAL_DR_TO_WIPER = 4'h1,
    OP_INCDEC = 4'h2,
    OP_READ_STATUS = 4'h5,
    OP_GLOBAL_WIPER_TO_DR = 4'h8,
    OP_READ_WIPER = 4'h9,
    OP_WRITE_WIPER = 4'hA,
    OP_READ_PRESET = 4'hB,
    OP_WRITE_PRESET = 4'hC,
    OP_DR_TO_WIPER = 4'hD,
    OP_WIPER_TO_DR = 4'hE
  } dps_op_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ID = 3'b001,
    ST_INSTR = 3'b010,
    ST_WRITE = 3'b011,
    ST_READ = 3'b100,
    ST_INCDEC = 3'b101,
    ST_DONE = 3'b110,
    ST_SKIP = 3'b111
  } dps_state_e;

  // Pin group, sampled together
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic [1:0] dev_sel;
  } dps_pins_s;

  localparam int PINS_W = 7;
  // Deselected, not held, not protected
  localparam logic [6:0] PINS_IDLE = 7'h4C;

  // Preset write staged until chip select rises
  typedef struct packed {
    logic valid;
    logic [1:0] pot_mask;
    logic [1:0] sel;
    logic [5:0] data0;
    logic [5:0] data1;
  } dps_stage_s;

  localparam logic [16:0] STAGE_EMPTY = 17'h00000;

endpackage

//--- src/dps_sync.sv
/*
 * Two flip-flop synchroniser for a group of pin inputs.
 * Assumes inputs are asynchronous to clk_in; reset is synchronous.
 */
module dps_sync #(
  parameter int W = 7,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);

  logic [W-1:0] meta;

  // First stage feeds only the second stage
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      meta <= RST_VAL;
      q_out <= RST_VAL;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule

//--- src/dps_tap_decode.sv
/*
 * One-hot tap switch decoder for one resistor array.
 * Assumes the wiper code comes from a flip-flop on the same clock.
 */
module dps_tap_decode (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [dps_pkg::WIPER_W-1:0] wiper_in,
  output logic [dps_pkg::TAPS-1:0] tap_en_out
);

  // Registered so no two switches overlap on a glitch
  genvar i;
  generate
    for (i = 0; i < dps_pkg::TAPS; i++) begin : g_tap
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          tap_en_out[i] <= (i == 0);
        end else begin
          tap_en_out[i] <= (wiper_in == dps_pkg::WIPER_W'(i));
        end
      end
    end
  endgenerate

endmodule

//--- src/dps_top.sv
/*
 * Serial control logic for a dual 64-tap digital potentiometer:
 * identification, instruction decode, wiper and preset registers,
 * nonvolatile write timing and the tap switch enables.
 * Assumes all serial pins are asynchronous and the serial clock is
 * much slower than clk_in, so its edges are found by sampling.
 */
// Notes on behaviour
// - Write-protect low blocks all preset writes
// - Serial input sampled on serial clock rise
// - Serial output driven only when returning data
// - At most one tap switch on per array
// - Wiper code decodes to one of 64 taps
// - Two independent wiper registers, one per pot
// - Write-wiper loads wiper from serial data
// - Copy instructions load wipers from chosen preset
// - Increment/decrement moves wiper one step each
// - Power-up loads wiper from preset zero
// - Four 6-bit presets per pot, read/write/exchange
// - Preset update finishes within 10 ms
// - Save starts on select rise after full write
// - Write-pending flag readable by status instruction
// - First byte after select falls is identification
// - Upper identification nibble must match type
// - Low identification bits must match address pins
// - Read bits shift out on serial clock fall
// - Deselected output floats; select fall needed first
// - Pause low while clock low freezes sequence
// - Second byte: opcode nibble, register, pot
module dps_top #(
  parameter int NV_WRITE_CYCLES = dps_pkg::NV_WRITE_CYCLES,
  parameter logic [3:0] DEV_TYPE = dps_pkg::DEV_TYPE_DEFAULT
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic si_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  input wire logic [1:0] device_select_pins_in,
  output logic so_out,
  output logic so_oe_n_out,
  output logic nv_write_pending_out,
  output logic [dps_pkg::TAPS-1:0] tap_en0_out,
  output logic [dps_pkg::TAPS-1:0] tap_en1_out
);

  dps_pkg::dps_pins_s pins_raw;
  dps_pkg::dps_pins_s pins;
  dps_pkg::dps_state_e state;
  dps_pkg::dps_state_e next_state;
  dps_pkg::dps_stage_s stage;
  logic sck_q;
  logic cs_q;
  logic rise;
  logic fall;
  logic cs_fall;
  logic cs_rise;
  logic running;
  logic [2:0] bit_cnt;
  logic [7:0] in_sr;
  logic [7:0] byte_now;
  logic byte_done;
  logic [7:0] out_sr;
  logic so_bit;
  logic [3:0] opcode;
  logic [1:0] reg_sel;
  logic pot_sel;
  logic recall;
  logic nv_busy;
  logic [dps_pkg::NV_CNT_W-1:0] nv_cnt;
  logic [5:0] wiper [dps_pkg::POTS];
  logic [5:0] preset [dps_pkg::POTS][dps_pkg::PRESETS];
  logic commit;

  assign pins_raw = '{cs_n: cs_n_in, sck: sck_in, si: si_in,
    hold_n: hold_n_in, wp_n: wp_n_in, dev_sel: device_select_pins_in};

  // All pins cross into clk_in through two flops; select resets low so
  // a select already low at release is not taken for a falling edge
  dps_sync #(
    .W(dps_pkg::PINS_W),
    .RST_VAL({1'b0, dps_pkg::PINS_IDLE[dps_pkg::PINS_W-2:0]})
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in(pins_raw),
    .q_out(pins)
  );

  // Edge history of the synchronised clock and select
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sck_q <= 1'b0;
      cs_q <= 1'b0;
    end else begin
      sck_q <= pins.sck;
      cs_q <= pins.cs_n;
    end
  end

  // Pause simply masks clock edges; state is kept as is
  assign running = ~pins.cs_n & pins.hold_n;
  assign rise = running & pins.sck & ~sck_q;
  assign fall = running & ~pins.sck & sck_q;
  // Select is seen low through reset, so only a real fall counts
  assign cs_fall = ~pins.cs_n & cs_q;
  assign cs_rise = pins.cs_n & ~cs_q;

  assign byte_now = {in_sr[6:0], pins.si};
  assign byte_done = rise & (bit_cnt == dps_pkg::BIT_LAST);
  assign opcode = byte_now[dps_pkg::OP_HI:dps_pkg::OP_LO];
  assign reg_sel = byte_now[dps_pkg::REG_HI:dps_pkg::REG_LO];
  assign pot_sel = byte_now[dps_pkg::POT_BIT];

  // Bit counter and input shifter, restarted at each select fall
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_fall) begin
      bit_cnt <= 3'h0;
      in_sr <= 8'h00;
    end else if (rise) begin
      bit_cnt <= bit_cnt + 3'h1;
      in_sr <= byte_now;
    end
  end

  // Sequence state
  always_comb begin
    next_state = state;
    if (pins.cs_n) begin
      next_state = dps_pkg::ST_IDLE;
    end else if (cs_fall) begin
      next_state = dps_pkg::ST_ID;
    end else if (byte_done) begin
      case (state)
        dps_pkg::ST_ID: begin
          if (byte_now[dps_pkg::ID_TYPE_HI:dps_pkg::ID_TYPE_LO] == DEV_TYPE
              && byte_now[dps_pkg::ID_ADDR_HI:dps_pkg::ID_ADDR_LO]
              == pins.dev_sel) begin
            next_state = dps_pkg::ST_INSTR;
          end else begin
            next_state = dps_pkg::ST_SKIP;
          end
        end
        dps_pkg::ST_INSTR: begin
          case (opcode)
            dps_pkg::OP_READ_WIPER, dps_pkg::OP_READ_PRESET,
            dps_pkg::OP_READ_STATUS: begin
              next_state = dps_pkg::ST_READ;
            end
            dps_pkg::OP_WRITE_WIPER, dps_pkg::OP_WRITE_PRESET: begin
              next_state = dps_pkg::ST_WRITE;
            end
            dps_pkg::OP_INCDEC: begin
              next_state = dps_pkg::ST_INCDEC;
            end
            dps_pkg::OP_DR_TO_WIPER, dps_pkg::OP_WIPER_TO_DR,
            dps_pkg::OP_GLOBAL_DR_TO_WIPER,
            dps_pkg::OP_GLOBAL_WIPER_TO_DR: begin
              next_state = dps_pkg::ST_DONE;
            end
            default: begin
              next_state = dps_pkg::ST_SKIP;
            end
          endcase
        end
        dps_pkg::ST_WRITE, dps_pkg::ST_READ: begin
          next_state = dps_pkg::ST_DONE;
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state <= dps_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Per-transfer register pointers, captured with the instruction
  logic [3:0] op_q;
  logic [1:0] reg_q;
  logic pot_q;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      op_q <= 4'h0;
      reg_q <= 2'h0;
      pot_q <= 1'b0;
    end else if (byte_done && state == dps_pkg::ST_INSTR) begin
      op_q <= opcode;
      reg_q <= reg_sel;
      pot_q <= pot_sel;
    end
  end

  // Read data loaded after the instruction, shifted out on falls
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      out_sr <= 8'h00;
      so_bit <= 1'b0;
    end else if (byte_done && state == dps_pkg::ST_INSTR) begin
      if (opcode == dps_pkg::OP_READ_WIPER) begin
        out_sr <= {2'h0, wiper[pot_sel]};
      end else if (opcode == dps_pkg::OP_READ_PRESET) begin
        out_sr <= {2'h0, preset[pot_sel][reg_sel]};
      end else begin
        out_sr <= {7'h00, nv_busy};
      end
    end else if (fall && state == dps_pkg::ST_READ) begin
      so_bit <= out_sr[7];
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // Output floats unless a read is under way and not paused
  assign so_out = so_bit;
  assign so_oe_n_out = ~(running && state == dps_pkg::ST_READ);

  // Preset writes wait here until select rises on a full sequence
  always_ff @(posedge clk_in) begin
    if (rst_in || cs_fall) begin
      stage <= dps_pkg::STAGE_EMPTY;
    end else if (byte_done && state == dps_pkg::ST_INSTR) begin
      if (opcode == dps_pkg::OP_WIPER_TO_DR) begin
        stage.valid <= 1'b1;
        stage.pot_mask <= pot_sel ? 2'b10 : 2'b01;
        stage.sel <= reg_sel;
        stage.data0 <= wiper[0];
        stage.data1 <= wiper[1];
      end else if (opcode == dps_pkg::OP_GLOBAL_WIPER_TO_DR) begin
        stage.valid <= 1'b1;
        stage.pot_mask <= 2'b11;
        stage.sel <= reg_sel;
        stage.data0 <= wiper[0];
        stage.data1 <= wiper[1];
      end
    end else if (byte_done && state == dps_pkg::ST_WRITE &&
                 op_q == dps_pkg::OP_WRITE_PRESET) begin
      stage.valid <= 1'b1;
      stage.pot_mask <= pot_q ? 2'b10 : 2'b01;
      stage.sel <= reg_q;
      stage.data0 <= byte_now[5:0];
      stage.data1 <= byte_now[5:0];
    end
  end

  // Commit needs a full sequence, protect high and no write running
  assign commit = cs_rise && stage.valid && state == dps_pkg::ST_DONE
    && pins.wp_n && !nv_busy;

  // Write-pending timer; commit lands when the timer expires
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nv_busy <= 1'b0;
      nv_cnt <= '0;
    end else if (commit) begin
      nv_busy <= 1'b1;
      nv_cnt <= dps_pkg::NV_CNT_W'(NV_WRITE_CYCLES - 1);
    end else if (nv_busy) begin
      if (nv_cnt == '0) begin
        nv_busy <= 1'b0;
      end else begin
        nv_cnt <= nv_cnt - 1'b1;
      end
    end
  end

  assign nv_write_pending_out = nv_busy;

  // Held copy of the committed write, applied as the timer ends
  dps_pkg::dps_stage_s nv_job;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      nv_job <= dps_pkg::STAGE_EMPTY;
    end else if (commit) begin
      nv_job <= stage;
    end
  end

  // Preset storage; contents change only when a save completes
  genvar p;
  genvar r;
  generate
    for (p = 0; p < dps_pkg::POTS; p++) begin : g_pot
      for (r = 0; r < dps_pkg::PRESETS; r++) begin : g_reg
        always_ff @(posedge clk_in) begin
          if (rst_in) begin
            preset[p][r] <= dps_pkg::PRESET_RESET;
          end else if (nv_busy && nv_cnt == '0 && nv_job.pot_mask[p]
                       && nv_job.sel == 2'(r)) begin
            preset[p][r] <= (p == 0) ? nv_job.data0 : nv_job.data1;
          end
        end
      end
    end
  endgenerate

  // One-shot recall of preset zero just after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      recall <= 1'b1;
    end else begin
      recall <= 1'b0;
    end
  end

  // Wiper registers, one per pot, with all load paths
  generate
    for (p = 0; p < dps_pkg::POTS; p++) begin : g_wiper
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          wiper[p] <= dps_pkg::WIPER_MIN;
        end else if (recall) begin
          wiper[p] <= preset[p][0];
        end else if (byte_done && state == dps_pkg::ST_INSTR &&
                     ((opcode == dps_pkg::OP_DR_TO_WIPER &&
                       pot_sel == 1'(p)) ||
                      opcode == dps_pkg::OP_GLOBAL_DR_TO_WIPER)) begin
          wiper[p] <= preset[p][reg_sel];
        end else if (byte_done && state == dps_pkg::ST_WRITE &&
                     op_q == dps_pkg::OP_WRITE_WIPER && pot_q == 1'(p)) begin
          wiper[p] <= byte_now[5:0];
        end else if (rise && state == dps_pkg::ST_INCDEC &&
                     pot_q == 1'(p)) begin
          // Saturate at the array ends rather than wrap across it
          if (pins.si && wiper[p] != dps_pkg::WIPER_MAX) begin
            wiper[p] <= wiper[p] + 6'h01;
          end else if (!pins.si && wiper[p] != dps_pkg::WIPER_MIN) begin
            wiper[p] <= wiper[p] - 6'h01;
          end
        end
      end
    end
  endgenerate

  // Tap switch decoders, one per array
  dps_tap_decode u_tap0 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wiper_in(wiper[0]),
    .tap_en_out(tap_en0_out)
  );

  dps_tap_decode u_tap1 (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .wiper_in(wiper[1]),
    .tap_en_out(tap_en1_out)
  );

endmodule

//--- testbench/dps_chk.sv
/*
 * Port-level checker for the dual pot serial block, bound into dps_top.
 * Assumes one clock domain and the synchronous active-high reset.
 */
module dps_chk #(
  parameter int NV_WRITE_CYCLES = dps_pkg::NV_WRITE_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  input wire logic so_out,
  input wire logic so_oe_n_out,
  input wire logic nv_write_pending_out,
  input wire logic [dps_pkg::TAPS-1:0] tap_en0_out,
  input wire logic [dps_pkg::TAPS-1:0] tap_en1_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pend_cnt;

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Length of the running write, so an endless one is caught
  always_ff @(posedge clk_in) begin
    if (rst_in || !nv_write_pending_out) begin
      pend_cnt <= '0;
    end else begin
      pend_cnt <= pend_cnt + 32'h1;
    end
  end

  AST_ONE_TAP0: assert property ($onehot(tap_en0_out))
    else $error("pot 0 tap enables not one-hot");
  AST_ONE_TAP1: assert property ($onehot(tap_en1_out))
    else $error("pot 1 tap enables not one-hot");
  AST_CS_FLOAT: assert property (cs_n_in [*4] |-> so_oe_n_out)
    else $error("output driven while deselected");
  AST_OE_SEL: assert property (
    !so_oe_n_out |-> !$past(cs_n_in, 2) && $past(hold_n_in, 2))
    else $error("output driven outside a selected frame");
  AST_SO_FALL: assert property (
    $changed(so_out) && !so_oe_n_out |-> !$past(sck_in, 2))
    else $error("read bit moved away from a clock fall");
  AST_PEND_CS: assert property (
    $rose(nv_write_pending_out) |-> $past(cs_n_in, 2))
    else $error("write started without select rise");
  AST_PEND_WP: assert property (
    $rose(nv_write_pending_out) |-> $past(wp_n_in, 3))
    else $error("write started while protected");
  AST_PEND_MAX: assert property (
    nv_write_pending_out |-> pend_cnt <= NV_WRITE_CYCLES)
    else $error("nonvolatile write too long");
  AST_TAP_SEL: assert property (
    $changed(tap_en0_out) || $changed(tap_en1_out) |-> !$past(cs_n_in, 2))
    else $error("wiper moved outside a frame");
endmodule

bind dps_top dps_chk #(.NV_WRITE_CYCLES(NV_WRITE_CYCLES)) i_dps_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .sck_in(sck_in),
  .hold_n_in(hold_n_in), .wp_n_in(wp_n_in), .so_out(so_out),
  .so_oe_n_out(so_oe_n_out), .nv_write_pending_out(nv_write_pending_out),
  .tap_en0_out(tap_en0_out), .tap_en1_out(tap_en1_out));

//--- testbench/dps_host.sv
/*
 * Serial host model: frames with select, clock and data in, reads data out.
 * Assumes clk_in is the 10 MHz system clock; serial clock is 800 ns.
 */
module dps_host (
  input wire logic clk_in,
  input wire logic so_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic si_out,
  output logic hold_n_out
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus; pause stays high unless a test pauses
  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    hold_n_out = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Pause moves only while the clock has been low a while
  task automatic pause(input logic on);
    step(4);
    hold_n_out = ~on;
    step(4);
  endtask

  // Select stays low for the whole frame
  task automatic start();
    cs_n_out = 1'b0;
    step(4);
  endtask

  // Released data line shows the inverse, never the last bit
  task automatic stop();
    step(4);
    cs_n_out = 1'b1;
    si_out = ~si_out;
    step(6);
  endtask

  // Data set while clock low, held over the rise; read just before rise
  task automatic xfer(input logic [7:0] b, input int nbits,
                      output logic [7:0] r);
    r = 8'h00;
    for (int i = 0; i < nbits; i++) begin
      si_out = b[7-i];
      step(4);
      r = {r[6:0], so_in};
      sck_out = 1'b1;
      step(4);
      sck_out = 1'b0;
    end
  endtask
endmodule

//--- testbench/testbench.sv
/*
 * Self-checking bench for dps_top driven through the serial host model.
 * Assumes the write time parameter is shortened to NVC system clocks.
 */
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int NVC = 400;
  localparam logic [3:0] DEV = 4'h6; // Arbitrary type code
  localparam logic [1:0] ADDR = 2'h2;
  localparam logic [7:0] ID = {DEV, 2'b00, ADDR};
  logic clk_in, rst_in, wp_n, cs_n, sck, si, hold_n, so, so_oe_n, pend;
  logic [1:0] dsel;
  logic [63:0] tap0, tap1;
  logic [7:0] rd;
  logic so_line;
  // A floating output shows the inverse of its last bit to the host
  assign so_line = so_oe_n ? ~so : so;
  int miscompares = 0;
  int checked = 0;

  dps_top #(.NV_WRITE_CYCLES(NVC), .DEV_TYPE(DEV)) i_dps_top (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck),
    .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n),
    .device_select_pins_in(dsel), .so_out(so), .so_oe_n_out(so_oe_n),
    .nv_write_pending_out(pend), .tap_en0_out(tap0), .tap_en1_out(tap1));
  dps_host i_dps_host (.clk_in(clk_in), .so_in(so_line), .cs_n_out(cs_n),
    .sck_out(sck), .si_out(si), .hold_n_out(hold_n));

  // System clock, 100 ns
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic check(input string what, input logic [63:0] seen,
                       input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic frame(input logic [7:0] id, input logic [7:0] ins,
                       input int dbits, input logic [7:0] d);
    logic [7:0] junk;
    i_dps_host.start();
    i_dps_host.xfer(id, 8, junk);
    i_dps_host.xfer(ins, 8, junk);
    rd = junk;
    if (dbits > 0) begin
      i_dps_host.xfer(d, dbits, rd);
    end
    i_dps_host.stop();
  endtask

  task automatic rdchk(input string what, input logic [7:0] ins,
                       input logic [7:0] exp);
    frame(ID, ins, 8, 8'h00);
    check(what, rd, exp);
  endtask

  // Bounded wait for the write to finish
  task automatic wait_nv();
    int n;
    n = 0;
    while (pend === 1'b1 && n < NVC + 20) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("pending end", pend, 1'b0);
  endtask

  task automatic final_report();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Tests take under 10000 clocks; twice that means a hang
  initial begin
    repeat (20000) @(posedge clk_in);
    miscompares++;
    final_report();
  end

  initial begin
    rst_in = 1'b1;
    wp_n = 1'b1;
    dsel = ADDR;
    repeat (6) @(posedge clk_in);
    #1;
    rst_in = 1'b0;
    i_dps_host.step(3);
    check("tap0 reset", tap0, 64'h1);
    check("tap1 reset", tap1, 64'h1);
    check("oe reset", so_oe_n, 1'b1);
    $display("test reset done");
    frame(ID, 8'hA1, 8, 8'h15);
    check("tap1 write", tap1, 64'h1 << 21);
    check("tap0 kept", tap0, 64'h1);
    frame(ID, 8'hA0, 8, 8'hFF);
    check("tap0 write", tap0, 64'h1 << 63);
    rdchk("wiper1", 8'h91, 8'h15);
    rdchk("wiper0", 8'h90, 8'h3F);
    $display("test wipers done");
    frame(ID, 8'h20, 5, 8'hC0);
    check("dec pot0", tap0, 64'h1 << 60);
    frame(ID, 8'h21, 3, 8'hE0);
    check("inc pot1", tap1, 64'h1 << 24);
    $display("test step done");
    frame(ID, 8'hC8, 8, 8'h2A);
    check("pending", pend, 1'b1);
    rdchk("status busy", 8'h50, 8'h01);
    wait_nv();
    rdchk("status idle", 8'h50, 8'h00);
    rdchk("preset0 2", 8'hB8, 8'h2A);
    frame(ID, 8'hD8, 0, 8'h00);
    check("copy pot0", tap0, 64'h1 << 42);
    frame(ID, 8'h10, 0, 8'h00);
    check("global pot0", tap0, 64'h1);
    check("global pot1", tap1, 64'h1);
    frame(ID, 8'hA1, 8, 8'h07);
    frame(ID, 8'hED, 0, 8'h00);
    wait_nv();
    rdchk("preset1 3", 8'hBD, 8'h07);
    frame(ID, 8'h84, 0, 8'h00);
    wait_nv();
    rdchk("preset1 1", 8'hB5, 8'h07);
    $display("test presets done");
    wp_n = 1'b0;
    frame(ID, 8'hC5, 8, 8'h11);
    check("protected", pend, 1'b0);
    wp_n = 1'b1;
    frame(ID, 8'hC5, 4, 8'h11);
    check("short write", pend, 1'b0);
    rdchk("preset kept", 8'hB5, 8'h07);
    frame({DEV, 2'b00, ~ADDR}, 8'hA1, 8, 8'h30);
    check("addr miss", tap1, 64'h1 << 7);
    frame({~DEV, 2'b00, ADDR}, 8'hA1, 8, 8'h30);
    check("type miss", tap1, 64'h1 << 7);
    $display("test refusals done");
    i_dps_host.start();
    i_dps_host.xfer(ID, 8, rd);
    i_dps_host.xfer(8'h21, 8, rd);
    i_dps_host.pause(1'b1);
    i_dps_host.xfer(8'hE0, 3, rd);
    i_dps_host.pause(1'b0);
    i_dps_host.xfer(8'h80, 1, rd);
    i_dps_host.stop();
    check("pause", tap1, 64'h1 << 8);
    frame(ID, 8'h31, 8, 8'h3F);
    check("bad opcode", tap1, 64'h1 << 8);
    $display("test pause done");
    // Select already low at reset release must not open a frame
    rst_in = 1'b1;
    i_dps_host.start();
    rst_in = 1'b0;
    i_dps_host.xfer(ID, 8, rd);
    i_dps_host.xfer(8'hA1, 8, rd);
    i_dps_host.xfer(8'h30, 8, rd);
    i_dps_host.stop();
    check("no select fall", tap1, 64'h1);
    $display("test reset select done");
    final_report();
  end
endmodule
